// *** hw/crop_capture_regs.vh ***
// register offsets, field positions and reset values of the crop capture block
// assumes byte addresses on a 32-bit avalon-mm slave
`ifndef CROP_CAPTURE_REGS_VH
`define CROP_CAPTURE_REGS_VH

`define CROP_WINDOW_START_OFS   8'h20
`define CROP_WINDOW_SIZE_OFS    8'h24
`define CAPTURED_DATA_WORD_OFS  8'h28
`define CROP_CONTROL_OFS        8'h2c

`define CROP_WINDOW_START_RST   32'h00000000
`define CROP_WINDOW_SIZE_RST    32'h00000000
`define CAPTURED_DATA_WORD_RST  32'h00000000
`define CROP_CONTROL_RST        32'h00000000

`define HSKIP_MSB   13
`define HSKIP_LSB   0
`define FIRST_MSB   28
`define FIRST_LSB   16
`define PIXCNT_MSB  13
`define PIXCNT_LSB  0
`define LINECNT_MSB 29
`define LINECNT_LSB 16

`define START_WMASK 32'h1fff3fff
`define SIZE_WMASK  32'h3fff3fff
`define CTRL_WMASK  32'h00000003

`endif

// *** hw/camera_crop_window_capture.v ***
// cropping window and data word packing of a parallel camera capture port
// assumes sensor pins asynchronous to i_clk; pixel clock well below i_clk/4
// How it works
// - skip the horizontal_skip_count pixel clocks at each line start before capturing
// - capture starts at line first_line_select of the frame, counting lines from zero
// - capture pixels_per_line_count plus one pixel clocks in each windowed line
// - capture window_line_count plus one lines, then stop for the frame
// - raise a dma request whenever a full 32-bit word is assembled
// - data word is read-only, byte_zero in bits 7:0, byte_three in 31:24
`timescale 1ns/10ps
`include "crop_capture_regs.vh"

module camera_crop_window_capture #(
  parameter DATA_W = 8
) (
  input  wire              i_clk,          // system clock, 50 mhz
  input  wire              i_reset,        // synchronous reset, active high
  input  wire [7:0]        i_address,      // avalon byte address
  input  wire              i_read,         // avalon read
  input  wire              i_write,        // avalon write
  input  wire [31:0]       i_writedata,    // avalon write data
  input  wire [3:0]        i_byteenable,   // avalon byte enables
  output reg  [31:0]       o_readdata,     // avalon read data
  output wire              o_waitrequest,  // avalon wait request
  input  wire              i_pixel_clock,  // sensor pixel clock
  input  wire              i_hsync,        // line valid, high active
  input  wire              i_vsync,        // frame valid, high active
  input  wire [DATA_W-1:0] i_pixel_data,   // sensor data byte
  output reg               o_dma_request,  // one-cycle pulse per packed word
  output wire              o_capture_busy  // inside an enabled frame
);

  // register file
  reg  [31:0] start_q;
  reg  [31:0] size_q;
  reg  [31:0] word_q;
  reg  [1:0]  ctrl_q;   // bit0 capture enable, bit1 crop enable
  reg         ack_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    input [31:0] wmask;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
      merge = merge & wmask;
    end
  endfunction

  // one wait cycle per access gives registered read data
  assign o_waitrequest = (i_read | i_write) & ~ack_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      ack_q      <= 1'b0;
      start_q    <= `CROP_WINDOW_START_RST;
      size_q     <= `CROP_WINDOW_SIZE_RST;
      ctrl_q     <= 2'h0;
      o_readdata <= 32'h00000000;
    end else begin
      ack_q <= (i_read | i_write) & ~ack_q;
      // a write lands only at the edge where waitrequest is low
      if (i_write & ack_q) begin
        case (i_address)
          `CROP_WINDOW_START_OFS: begin
            start_q <= merge(start_q, i_writedata, i_byteenable, `START_WMASK);
          end
          `CROP_WINDOW_SIZE_OFS: begin
            size_q <= merge(size_q, i_writedata, i_byteenable, `SIZE_WMASK);
          end
          `CROP_CONTROL_OFS: begin
            ctrl_q <= i_byteenable[0] ? i_writedata[1:0] : ctrl_q;
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
      if (i_read & ~ack_q) begin
        case (i_address)
          `CROP_WINDOW_START_OFS:  o_readdata <= start_q;
          `CROP_WINDOW_SIZE_OFS:   o_readdata <= size_q;
          `CAPTURED_DATA_WORD_OFS: o_readdata <= word_q;
          `CROP_CONTROL_OFS:       o_readdata <= {29'h0, o_capture_busy, ctrl_q};
          default:                 o_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // synchronisers for sensor pins
  reg [2:0]        pclk_s;
  reg [1:0]        hs_s;
  reg [1:0]        vs_s;
  reg [DATA_W-1:0] dat_s1;
  reg [DATA_W-1:0] dat_s2;
  reg              hs_prev_q;
  reg              vs_prev_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      pclk_s    <= 3'h0;
      hs_s      <= 2'h0;
      vs_s      <= 2'h0;
      dat_s1    <= {DATA_W{1'b0}};
      dat_s2    <= {DATA_W{1'b0}};
      hs_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
    end else begin
      pclk_s    <= {pclk_s[1:0], i_pixel_clock};
      hs_s      <= {hs_s[0], i_hsync};
      vs_s      <= {vs_s[0], i_vsync};
      dat_s1    <= i_pixel_data;
      dat_s2    <= dat_s1;
      hs_prev_q <= hs_s[1];
      vs_prev_q <= vs_s[1];
    end
  end

  // pixel clock rising edge, seen on the settled stages only
  wire pix_edge    = pclk_s[1] & ~pclk_s[2];
  wire frame_start = vs_s[1] & ~vs_prev_q;
  wire line_start  = hs_s[1] & ~hs_prev_q;

  wire [13:0] hskip     = start_q[`HSKIP_MSB:`HSKIP_LSB];
  wire [12:0] first_sel = start_q[`FIRST_MSB:`FIRST_LSB];
  wire [13:0] pix_cnt   = size_q[`PIXCNT_MSB:`PIXCNT_LSB];
  wire [13:0] line_cnt  = size_q[`LINECNT_MSB:`LINECNT_LSB];

  reg         in_frame_q;
  reg  [13:0] line_idx_q;    // lines seen so far in the frame
  reg  [14:0] pix_idx_q;     // pixel clocks seen so far in the line
  reg  [1:0]  byte_sel_q;
  reg  [23:0] pack_q;

  assign o_capture_busy = in_frame_q;

  // line index counts from 0; line first_sel is the window's first line
  wire line_in_win = ~ctrl_q[1] |
                     ((line_idx_q >= {1'b0, first_sel}) &&
                      (line_idx_q - {1'b0, first_sel} <= line_cnt));
  wire pix_in_win  = ~ctrl_q[1] |
                     ((pix_idx_q >= {1'b0, hskip}) &&
                      (pix_idx_q - {1'b0, hskip} <= {1'b0, pix_cnt}));
  wire take = in_frame_q & hs_s[1] & pix_edge & line_in_win & pix_in_win;

  always @(posedge i_clk) begin
    if (i_reset) begin
      in_frame_q    <= 1'b0;
      line_idx_q    <= 14'h0;
      pix_idx_q     <= 15'h0;
      byte_sel_q    <= 2'h0;
      pack_q        <= 24'h0;
      word_q        <= `CAPTURED_DATA_WORD_RST;
      o_dma_request <= 1'b0;
    end else begin
      o_dma_request <= 1'b0;
      if (frame_start) begin
        in_frame_q   <= ctrl_q[0];
        line_idx_q   <= 14'h0;
        pix_idx_q    <= 15'h0;
        byte_sel_q   <= 2'h0;
      end else if (~vs_s[1]) begin
        in_frame_q <= 1'b0;
      end else begin
        if (line_start) begin
          pix_idx_q <= 15'h0;
        end else if (hs_s[1] & pix_edge & (pix_idx_q != 15'h7fff)) begin
          pix_idx_q <= pix_idx_q + 15'h1;
        end
        // line end: advance the line count
        if (~hs_s[1] & hs_prev_q & (line_idx_q != 14'h3fff)) begin
          line_idx_q <= line_idx_q + 14'h1;
        end
        if (take) begin
          case (byte_sel_q)
            2'h0: pack_q[7:0]   <= dat_s2;
            2'h1: pack_q[15:8]  <= dat_s2;
            2'h2: pack_q[23:16] <= dat_s2;
            default: begin
              word_q        <= {dat_s2, pack_q};
              o_dma_request <= 1'b1;
            end
          endcase
          byte_sel_q <= byte_sel_q + 2'h1;
        end
      end
    end
  end

endmodule // camera_crop_window_capture

// *** testbench/crop_checker.sv ***
// port assertions for the crop capture block
// assumes binding onto camera_crop_window_capture
`timescale 1ns/10ps
`include "crop_capture_regs.vh"
module crop_checker (
  input wire        i_clk,
  input wire        i_reset,
  input wire [7:0]  i_address,
  input wire        i_read,
  input wire        i_hsync,
  input wire        i_vsync,
  input wire [31:0] o_readdata,
  input wire        o_waitrequest,
  input wire        o_dma_request,
  input wire        o_capture_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire rd = i_read && !o_waitrequest;
  a_dma_pulse: assert property (o_dma_request |=> !o_dma_request [*8])
    else $error("dma pulse too long");
  a_dma_frame: assert property (o_dma_request |-> o_capture_busy)
    else $error("dma outside frame");
  a_dma_line: assert property (o_dma_request |-> $past(i_hsync, 3))
    else $error("dma without line");
  a_start_rsvd: assert property (rd && i_address == 8'h20 |->
    (o_readdata & ~`START_WMASK) == 32'h0) else $error("start reserved set");
  a_size_rsvd: assert property (rd && i_address == 8'h24 |->
    (o_readdata & ~`SIZE_WMASK) == 32'h0) else $error("size reserved set");
  a_idle_busy: assert property (!i_vsync [*8] |=> !o_capture_busy)
    else $error("busy without frame");
  a_busy_start: assert property ($rose(o_capture_busy) |-> $past(i_vsync, 2))
    else $error("busy without vsync");
  c_dma: cover property (o_dma_request);
  c_busy: cover property ($rose(o_capture_busy));
  c_word: cover property (rd && i_address == 8'h28);
endmodule // crop_checker
bind camera_crop_window_capture crop_checker crop_checker_i (.*);

// *** testbench/sensor_model.sv ***
// sensor stand-in: byte = line*16 + pixel, 160 ns pixel clock
// clock still outside lines; data inverted when not valid
`timescale 1ns/10ps
module sensor_model (
  output logic       o_pclk, // pixel clock
  output logic       o_hs,   // line valid
  output logic       o_vs,   // frame valid
  output logic [7:0] o_d     // pixel byte
);
  initial begin o_pclk = 0; o_hs = 0; o_vs = 0; o_d = 8'hff; end
  task frame(input int nl, input int np);
    #7 o_vs = 1;
    #400;
    for (int l = 0; l < nl; l++) begin
      o_hs = 1;
      for (int p = 0; p < np; p++) begin
        o_d = 8'(l * 16 + p);
        #80 o_pclk = 1;
        #80 o_pclk = 0;
      end
      o_d = ~o_d;
      #80 o_hs = 0;
      #400;
    end
    o_vs = 0;
    #400;
  endtask
endmodule // sensor_model

// *** testbench/tb.sv ***
// self-checking bench for the crop capture block
// avalon master tasks here; sensor_model drives the pixel side
`timescale 1ns/10ps
module tb;
  logic        i_clk, i_reset, i_read, i_write;
  logic [7:0]  i_address;
  logic [31:0] i_writedata, q;
  logic [3:0]  be;
  wire  [31:0] o_readdata;
  wire         o_waitrequest, o_dma_request, o_capture_busy, pclk, hs, vs;
  wire  [7:0]  pd;
  int          miscompares, check_count, dmas;
  camera_crop_window_capture camera_crop_window_capture_i (.i_clk(i_clk),
    .i_reset(i_reset), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(be), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_pixel_clock(pclk), .i_hsync(hs), .i_vsync(vs),
    .i_pixel_data(pd), .o_dma_request(o_dma_request), .o_capture_busy(o_capture_busy));
  sensor_model sensor_model_i (.o_pclk(pclk), .o_hs(hs), .o_vs(vs), .o_d(pd));
  initial begin i_clk = 0; forever #10 i_clk = ~i_clk; end
  always @(posedge i_clk) if (o_dma_request === 1'b1) dmas++;
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, s, e); end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_read <= !w; i_write <= w; i_address <= a; i_writedata <= d;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 0; i_write <= 0;
  endtask
  task regs_test;
    bus(0, 8'h20, 0); chk(q, 32'h0);
    bus(0, 8'h24, 0); chk(q, 32'h0);
    bus(0, 8'h28, 0); chk(q, 32'h0);
    bus(1, 8'h20, '1); bus(0, 8'h20, 0); chk(q, 32'h1fff3fff);
    bus(1, 8'h24, '1); bus(0, 8'h24, 0); chk(q, 32'h3fff3fff);
    bus(1, 8'h28, '1); bus(0, 8'h28, 0); chk(q, 32'h0);
    be <= 4'h1;
    bus(1, 8'h20, 0);
    be <= 4'hf;
    bus(0, 8'h20, 0); chk(q, 32'h1fff3f00);
    bus(0, 8'h30, 0); chk(q, 32'h0);
    bus(1, 8'h2c, 32'h3);
    bus(0, 8'h2c, 0); chk(q, 32'h3);
  endtask
  task mode_test;
    bus(1, 8'h2c, 32'h1);
    run(32'h0, 32'h0, 2);
    chk(32'(dmas), 32'h4);
    chk(q, 32'h17161514);
    bus(1, 8'h2c, 32'h0);
    run(32'h0, 32'h0, 2);
    chk(32'(dmas), 32'h0);
    chk(q, 32'h17161514);
    chk({31'h0, o_capture_busy}, 32'h0);
  endtask
  task run(input logic [31:0] st, input logic [31:0] sz, input int nl);
    bus(1, 8'h20, st); bus(1, 8'h24, sz);
    dmas = 0;
    sensor_model_i.frame(nl, 8);
    bus(0, 8'h28, 0);
  endtask
  task window_test;
    run(32'h00010001, 32'h00010003, 4);
    chk(32'(dmas), 32'h2);
    chk(q, 32'h24232221);
  endtask
  task origin_test;
    run(32'h0, 32'h00000007, 3);
    chk(32'(dmas), 32'h2);
    chk(q, 32'h07060504);
  endtask
  initial begin #200000; miscompares++; close_out; end
  initial begin
    i_reset = 1; i_read = 0; i_write = 0; i_address = 0; i_writedata = 0; be = 4'hf;
    repeat (3) @(posedge i_clk);
    i_reset <= 0;
    regs_test;
    window_test;
    origin_test;
    mode_test;
    close_out;
  end
endmodule // tb
